/* File: logic/csp_device.sv */
// Functional notes
// - Master holds frame select low 27-35 clocks
// - Data changes only while clock low
// - Transfers open with start, close with stop
// - Device pulls ack low through clock high
// - Master gives ninth clock for ack
// - Master ends read by withholding ack
// - Device releases data line after master nack
// - Precharge timer: enable, five-bit code, resets zero
// - Constant-current timer enable bit, resets zero
// - Total timer four-bit hour limit
// - Three temperature thresholds, eight bits each
// - Sense code, termination ratio, regulation select
// - Battery voltage result, read only
// - Thermistor and auxiliary results, read only
// - Fixed address, write E4h, read E5h
// - MSB first, idle when both lines high
// - Frame: dead bits, address, register, data
// - Sample on rise, commit 26th, abort early
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module csp_device
	import csp_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	csp_if.dev LINK,
	input wire logic [7:0] BATT_CODE,
	input wire logic [7:0] THERM_CODE,
	input wire logic [7:0] AUX1_CODE,
	input wire logic [7:0] AUX2_CODE,
	output logic [7:0] PRECHARGE_TIMER,
	output logic [7:0] CONST_CURRENT_TIMER,
	output logic [7:0] TOTAL_CHARGE_TIMER,
	output logic [7:0] TEMP_LIMIT_HIGH_UPPER,
	output logic [7:0] TEMP_LIMIT_HIGH_LOWER,
	output logic [7:0] TEMP_LIMIT_LOW,
	output logic [7:0] SENSE_AND_TERMINATION
);
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} csp_dev_state_t;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [1:0] ce_sync_reg;
	logic scl_s;
	logic sda_s;
	logic ce_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			ce_sync_reg <= 2'h3;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[1:0], LINK.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], LINK.sda};
			ce_sync_reg <= {ce_sync_reg[0], LINK.ce_n};
		end
	end

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign ce_s = ce_sync_reg[1];
	assign scl_rise = scl_s & ~scl_sync_reg[2];
	assign scl_fall = ~scl_s & scl_sync_reg[2];
	// Data edges while clock high are framing, never data
	assign start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
	assign stop_det = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	logic [7:0] precharge_reg;
	logic [7:0] cc_timer_reg;
	logic [7:0] total_reg;
	logic [7:0] temp_hu_reg;
	logic [7:0] temp_hl_reg;
	logic [7:0] temp_lo_reg;
	logic [7:0] sense_reg;
	logic i2c_wr_reg;
	logic spi_wr_reg;
	logic [7:0] i2c_ptr_reg;
	logic [7:0] spi_ptr_reg;
	logic [7:0] i2c_wdata_reg;
	logic [7:0] spi_wdata_reg;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		case (addr)
			OFS_PRECHARGE: reg_read = precharge_reg;
			OFS_CC_TIMER: reg_read = cc_timer_reg;
			OFS_TOTAL: reg_read = total_reg;
			OFS_TEMP_HU: reg_read = temp_hu_reg;
			OFS_TEMP_HL: reg_read = temp_hl_reg;
			OFS_TEMP_LO: reg_read = temp_lo_reg;
			OFS_SENSE: reg_read = sense_reg;
			OFS_BATT: reg_read = BATT_CODE;
			OFS_THERM: reg_read = THERM_CODE;
			OFS_AUX1: reg_read = AUX1_CODE;
			OFS_AUX2: reg_read = AUX2_CODE;
			default: reg_read = RST_ZERO;
		endcase
	endfunction

	assign wr_en = i2c_wr_reg | spi_wr_reg;
	assign wr_addr = i2c_wr_reg ? i2c_ptr_reg : spi_ptr_reg;
	assign wr_data = i2c_wr_reg ? i2c_wdata_reg : spi_wdata_reg;

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			precharge_reg <= RST_ZERO;
			cc_timer_reg <= RST_ZERO;
			total_reg <= RST_TOTAL;
			temp_hu_reg <= RST_ZERO;
			temp_hl_reg <= RST_ZERO;
			temp_lo_reg <= RST_ZERO;
			sense_reg <= RST_ZERO;
		end
		else if (wr_en)
		begin
			// Don't-care bits are stored as zero; result registers ignore writes
			case (wr_addr)
				OFS_PRECHARGE: precharge_reg <= wr_data & MASK_PRECHARGE;
				OFS_CC_TIMER: cc_timer_reg <= wr_data & MASK_CC;
				OFS_TOTAL: total_reg <= wr_data & MASK_TOTAL;
				OFS_TEMP_HU: temp_hu_reg <= wr_data;
				OFS_TEMP_HL: temp_hl_reg <= wr_data;
				OFS_TEMP_LO: temp_lo_reg <= wr_data;
				OFS_SENSE: sense_reg <= wr_data & MASK_SENSE;
				default: ;
			endcase
		end
	end

	assign PRECHARGE_TIMER = precharge_reg;
	assign CONST_CURRENT_TIMER = cc_timer_reg;
	assign TOTAL_CHARGE_TIMER = total_reg;
	assign TEMP_LIMIT_HIGH_UPPER = temp_hu_reg;
	assign TEMP_LIMIT_HIGH_LOWER = temp_hl_reg;
	assign TEMP_LIMIT_LOW = temp_lo_reg;
	assign SENSE_AND_TERMINATION = sense_reg;

	// ----------------------------------------
	// Two-wire slave
	// ----------------------------------------
	csp_dev_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] rx_sh_reg;
	logic [7:0] tx_sh_reg;
	logic rw_reg;
	logic nack_reg;
	logic i2c_oe_reg;
	logic [7:0] i2c_rd;

	assign i2c_rd = reg_read(i2c_ptr_reg);

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			rx_sh_reg <= 8'h00;
			tx_sh_reg <= 8'h00;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			i2c_oe_reg <= 1'b0;
			i2c_ptr_reg <= 8'h00;
			i2c_wdata_reg <= 8'h00;
			i2c_wr_reg <= 1'b0;
		end
		else
		begin
			i2c_wr_reg <= 1'b0;
			if (!ce_s)
			begin
				state_reg <= ST_IDLE;
				i2c_oe_reg <= 1'b0;
			end
			else if (start_det)
			begin
				state_reg <= ST_RX;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= 2'h0;
				i2c_oe_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				state_reg <= ST_IDLE;
				i2c_oe_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_RX:
						if (scl_rise)
						begin
							rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall && bit_cnt_reg == BYTE_BITS)
						begin
							bit_cnt_reg <= 4'h0;
							state_reg <= ST_ACK;
							i2c_oe_reg <= 1'b1;
							case (byte_idx_reg)
								2'h0:
									if (rx_sh_reg[7:1] == DEV_ADDR)
										rw_reg <= rx_sh_reg[0];
									else
									begin
										state_reg <= ST_IDLE;
										i2c_oe_reg <= 1'b0;
									end
								2'h1: i2c_ptr_reg <= rx_sh_reg;
								default:
								begin
									i2c_wdata_reg <= rx_sh_reg;
									i2c_wr_reg <= 1'b1;
								end
							endcase
						end
					ST_ACK:
						if (scl_fall)
						begin
							if (rw_reg && byte_idx_reg == 2'h0)
							begin
								tx_sh_reg <= {i2c_rd[6:0], 1'b0};
								i2c_oe_reg <= ~i2c_rd[7];
								bit_cnt_reg <= 4'h1;
								state_reg <= ST_TX;
							end
							else
							begin
								i2c_oe_reg <= 1'b0;
								state_reg <= ST_RX;
								// Further data bytes rewrite the same register
								if (byte_idx_reg != 2'h2)
									byte_idx_reg <= byte_idx_reg + 2'h1;
							end
						end
					ST_TX:
						if (scl_fall)
						begin
							if (bit_cnt_reg == BYTE_BITS)
							begin
								i2c_oe_reg <= 1'b0;
								state_reg <= ST_MACK;
							end
							else
							begin
								i2c_oe_reg <= ~tx_sh_reg[7];
								tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					ST_MACK:
						if (scl_rise)
							nack_reg <= sda_s;
						else if (scl_fall)
						begin
							if (nack_reg)
							begin
								i2c_oe_reg <= 1'b0;
								state_reg <= ST_IDLE;
							end
							else
							begin
								tx_sh_reg <= {i2c_rd[6:0], 1'b0};
								i2c_oe_reg <= ~i2c_rd[7];
								bit_cnt_reg <= 4'h1;
								state_reg <= ST_TX;
							end
						end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Three-wire frame
	// ----------------------------------------
	logic [5:0] spi_cnt_reg;
	logic [7:0] spi_sh_reg;
	logic [7:0] spi_dev_reg;
	logic [7:0] spi_tx_reg;
	logic spi_oe_reg;
	logic [5:0] spi_cnt_next;
	logic [7:0] spi_sh_next;
	logic [7:0] spi_rd;

	assign spi_cnt_next = spi_cnt_reg + 6'h01;
	assign spi_sh_next = {spi_sh_reg[6:0], sda_s};
	assign spi_rd = reg_read(spi_ptr_reg);

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			spi_cnt_reg <= 6'h00;
			spi_sh_reg <= 8'h00;
			spi_dev_reg <= 8'h00;
			spi_tx_reg <= 8'h00;
			spi_oe_reg <= 1'b0;
			spi_ptr_reg <= 8'h00;
			spi_wdata_reg <= 8'h00;
			spi_wr_reg <= 1'b0;
		end
		else
		begin
			spi_wr_reg <= 1'b0;
			if (ce_s)
			begin
				// Early rise drops the frame before any commit
				spi_cnt_reg <= 6'h00;
				spi_dev_reg <= 8'h00;
				spi_oe_reg <= 1'b0;
			end
			else if (scl_rise && spi_cnt_reg != SPI_LAST_CLK)
			begin
				spi_cnt_reg <= spi_cnt_next;
				spi_sh_reg <= spi_sh_next;
				if (spi_cnt_next == SPI_DEV_LAST)
					spi_dev_reg <= spi_sh_next;
				if (spi_cnt_next == SPI_REG_LAST)
					spi_ptr_reg <= spi_sh_next;
				if (spi_cnt_next == SPI_COMMIT && spi_dev_reg == ADDR_WR)
				begin
					spi_wdata_reg <= spi_sh_next;
					spi_wr_reg <= 1'b1;
				end
			end
			else if (scl_fall)
			begin
				// No acknowledge in this mode; line turns only for read data
				if (spi_dev_reg == ADDR_RD && spi_cnt_reg == SPI_REG_LAST)
				begin
					spi_oe_reg <= ~spi_rd[7];
					spi_tx_reg <= {spi_rd[6:0], 1'b0};
				end
				else if (spi_dev_reg == ADDR_RD && spi_cnt_reg > SPI_REG_LAST
					&& spi_cnt_reg < SPI_COMMIT)
				begin
					spi_oe_reg <= ~spi_tx_reg[7];
					spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
				end
				else
					spi_oe_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Data line driver
	// ----------------------------------------
	logic dev_oe_reg;

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			dev_oe_reg <= 1'b0;
		else
			dev_oe_reg <= i2c_oe_reg | spi_oe_reg;
	end

	assign LINK.dev_sda_o = 1'b0;
	assign LINK.dev_sda_oe = dev_oe_reg;
endmodule

/* File: logic/csp_pkg.sv */
package csp_pkg;
	// ----------------------------------------
	// Bus addressing
	// ----------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h72;
	localparam logic [7:0] ADDR_WR = 8'he4;
	localparam logic [7:0] ADDR_RD = 8'he5;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// ----------------------------------------
	// Charger register map
	// ----------------------------------------
	localparam logic [7:0] OFS_PRECHARGE = 8'h10;
	localparam logic [7:0] OFS_CC_TIMER = 8'h11;
	localparam logic [7:0] OFS_TOTAL = 8'h12;
	localparam logic [7:0] OFS_TEMP_HU = 8'h13;
	localparam logic [7:0] OFS_TEMP_HL = 8'h14;
	localparam logic [7:0] OFS_TEMP_LO = 8'h15;
	localparam logic [7:0] OFS_SENSE = 8'h16;
	localparam logic [7:0] OFS_BATT = 8'h17;
	localparam logic [7:0] OFS_THERM = 8'h18;
	localparam logic [7:0] OFS_AUX1 = 8'h19;
	localparam logic [7:0] OFS_AUX2 = 8'h1a;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TOTAL = 8'hf0;
	localparam logic [7:0] MASK_PRECHARGE = 8'hfc;
	localparam logic [7:0] MASK_CC = 8'h80;
	localparam logic [7:0] MASK_TOTAL = 8'hf0;
	localparam logic [7:0] MASK_SENSE = 8'hfe;
	// ----------------------------------------
	// Three-wire frame positions (rising edges)
	// ----------------------------------------
	localparam logic [5:0] SPI_DEV_LAST = 6'h0a;
	localparam logic [5:0] SPI_REG_LAST = 6'h12;
	localparam logic [5:0] SPI_COMMIT = 6'h1a;
	localparam logic [5:0] SPI_LAST_CLK = 6'h1b;
	localparam int SPI_FRAME_BITS = 26;
	// ----------------------------------------
	// Host command registers
	// ----------------------------------------
	localparam logic [2:0] H_CTRL = 3'h0;
	localparam logic [2:0] H_REG = 3'h1;
	localparam logic [2:0] H_WDATA = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_RDATA = 3'h4;
	localparam int CTRL_GO = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_SPI = 2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int I2C_QUARTER_NS = 625;
	localparam int SPI_QUARTER_NS = 125;
	localparam int I2C_QUARTER_CYC = (I2C_QUARTER_NS * CLK_MHZ + 999) / 1000;
	localparam int SPI_QUARTER_CYC = (SPI_QUARTER_NS * CLK_MHZ + 999) / 1000;
endpackage

/* File: logic/csp_if.sv */
`timescale 1ns/1ps
interface csp_if;
	logic scl;
	logic ce_n;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	// Open-drain data line with pull-up
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output scl, output ce_n, output host_sda_o, output host_sda_oe, input sda);
	modport dev (input scl, input ce_n, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

/* File: logic/csp_host.sv */
`timescale 1ns/1ps
module csp_host
	import csp_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	csp_if.host LINK,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA
);
	typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP, HS_SPI} csp_host_state_t;

	// ----------------------------------------
	// Command registers
	// ----------------------------------------
	csp_host_state_t state_reg;
	logic [7:0] reg_ptr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rx_reg;
	logic [7:0] rdata_reg;
	logic rd_mode_reg;
	logic spi_mode_reg;
	logic nack_reg;
	logic go;

	assign go = WR && ADDR == H_CTRL && WDATA[CTRL_GO] && state_reg == HS_IDLE;

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			reg_ptr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			rd_mode_reg <= 1'b0;
			spi_mode_reg <= 1'b0;
		end
		else if (WR && state_reg == HS_IDLE)
		begin
			case (ADDR)
				H_CTRL:
				begin
					rd_mode_reg <= WDATA[CTRL_READ];
					spi_mode_reg <= WDATA[CTRL_SPI];
				end
				H_REG: reg_ptr_reg <= WDATA;
				H_WDATA: wdata_reg <= WDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			rdata_reg <= 8'h00;
		else if (RD)
		begin
			case (ADDR)
				H_REG: rdata_reg <= reg_ptr_reg;
				H_WDATA: rdata_reg <= wdata_reg;
				H_STATUS: rdata_reg <= {6'h00, nack_reg, state_reg != HS_IDLE};
				H_RDATA: rdata_reg <= rx_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign RDATA = rdata_reg;

	// ----------------------------------------
	// Quarter-bit divider and data sync
	// ----------------------------------------
	logic [7:0] div_reg;
	logic tick;
	logic [1:0] sda_sync_reg;
	logic sda_s;

	assign tick = state_reg != HS_IDLE && div_reg == 8'h00;
	assign sda_s = sda_sync_reg[1];

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			div_reg <= 8'h00;
			sda_sync_reg <= 2'h3;
		end
		else
		begin
			sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
			if (go || div_reg == 8'h00)
				div_reg <= (go ? WDATA[CTRL_SPI] : spi_mode_reg)
					? 8'(SPI_QUARTER_CYC - 1) : 8'(I2C_QUARTER_CYC - 1);
			else
				div_reg <= div_reg - 8'h01;
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	logic [1:0] q_reg;
	logic [5:0] bit_reg;
	logic [1:0] idx_reg;
	logic [7:0] tx_reg;
	logic [SPI_FRAME_BITS-1:0] frame_reg;
	logic ack_reg;
	logic scl_reg;
	logic ce_n_reg;
	logic oe_reg;

	function automatic logic [7:0] host_byte(input logic [1:0] idx, input logic rd,
		input logic [7:0] ptr, input logic [7:0] data);
		case (idx)
			2'h0: host_byte = ADDR_WR;
			2'h1: host_byte = ptr;
			default: host_byte = rd ? ADDR_RD : data;
		endcase
	endfunction

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_reg <= HS_IDLE;
			q_reg <= 2'h0;
			bit_reg <= 6'h00;
			idx_reg <= 2'h0;
			tx_reg <= 8'h00;
			frame_reg <= '0;
			rx_reg <= 8'h00;
			ack_reg <= 1'b0;
			nack_reg <= 1'b0;
			scl_reg <= 1'b1;
			ce_n_reg <= 1'b1;
			oe_reg <= 1'b0;
		end
		else if (go)
		begin
			nack_reg <= 1'b0;
			q_reg <= 2'h0;
			idx_reg <= 2'h0;
			bit_reg <= 6'h01;
			if (WDATA[CTRL_SPI])
			begin
				state_reg <= HS_SPI;
				ce_n_reg <= 1'b0;
				frame_reg <= {2'h0, WDATA[CTRL_READ] ? ADDR_RD : ADDR_WR, reg_ptr_reg,
					wdata_reg};
			end
			else
				state_reg <= HS_START;
		end
		else if (tick)
		begin
			q_reg <= q_reg + 2'h1;
			case (state_reg)
				HS_START:
					case (q_reg)
						2'h0: oe_reg <= 1'b0;
						2'h1: scl_reg <= 1'b1;
						2'h2: oe_reg <= 1'b1;
						default:
						begin
							scl_reg <= 1'b0;
							bit_reg <= 6'h00;
							tx_reg <= host_byte(idx_reg, rd_mode_reg, reg_ptr_reg, wdata_reg);
							state_reg <= HS_BYTE;
						end
					endcase
				HS_BYTE:
					case (q_reg)
						// Read byte and its ninth bit leave the line released
						2'h0:
						begin
							oe_reg <= bit_reg < 6'h08 && idx_reg != 2'h3 && !tx_reg[7];
							tx_reg <= {tx_reg[6:0], 1'b0};
						end
						2'h1: scl_reg <= 1'b1;
						2'h2:
							if (bit_reg < 6'h08)
								rx_reg <= {rx_reg[6:0], sda_s};
							else
								ack_reg <= sda_s;
						default:
						begin
							scl_reg <= 1'b0;
							if (bit_reg < 6'h08)
								bit_reg <= bit_reg + 6'h01;
							else if (idx_reg != 2'h3 && ack_reg)
							begin
								nack_reg <= 1'b1;
								state_reg <= HS_STOP;
							end
							else if (idx_reg == 2'h3 || (!rd_mode_reg && idx_reg == 2'h2))
								state_reg <= HS_STOP;
							else if (rd_mode_reg && idx_reg == 2'h1)
							begin
								idx_reg <= 2'h2;
								state_reg <= HS_START;
							end
							else
							begin
								idx_reg <= idx_reg + 2'h1;
								bit_reg <= 6'h00;
								tx_reg <= host_byte(idx_reg + 2'h1, rd_mode_reg, reg_ptr_reg,
									wdata_reg);
							end
						end
					endcase
				HS_STOP:
					case (q_reg)
						2'h0: oe_reg <= 1'b1;
						2'h1: scl_reg <= 1'b1;
						2'h2: oe_reg <= 1'b0;
						default: state_reg <= HS_IDLE;
					endcase
				HS_SPI:
					case (q_reg)
						2'h0:
						begin
							scl_reg <= 1'b0;
							oe_reg <= bit_reg < SPI_LAST_CLK
								&& !(rd_mode_reg && bit_reg > SPI_REG_LAST)
								&& !frame_reg[SPI_FRAME_BITS-1];
							frame_reg <= {frame_reg[SPI_FRAME_BITS-2:0], 1'b0};
						end
						2'h1: scl_reg <= 1'b1;
						2'h2: ;
						default:
							if (bit_reg == SPI_LAST_CLK)
							begin
								ce_n_reg <= 1'b1;
								state_reg <= HS_IDLE;
							end
							else
							begin
								if (rd_mode_reg && bit_reg > SPI_REG_LAST)
									rx_reg <= {rx_reg[6:0], sda_s};
								bit_reg <= bit_reg + 6'h01;
							end
					endcase
				default: state_reg <= HS_IDLE;
			endcase
		end
	end

	assign LINK.scl = scl_reg;
	assign LINK.ce_n = ce_n_reg;
	assign LINK.host_sda_o = 1'b0;
	assign LINK.host_sda_oe = oe_reg;
endmodule

/* File: testbench/csp_link_sva.sv */
`timescale 1ns/1ps
module csp_link_sva
	import csp_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic scl,
	input wire logic ce_n,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	logic scl_q_reg;
	logic [5:0] rise_cnt_reg;
	// ----------------------------------------
	// Frame clock counter
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			scl_q_reg <= 1'b1;
		else
			scl_q_reg <= scl;
	end
	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			rise_cnt_reg <= 6'h00;
		else if (ce_n)
			rise_cnt_reg <= 6'h00;
		else if (scl && !scl_q_reg)
			rise_cnt_reg <= rise_cnt_reg + 6'h01;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	sequence clk_parked;
		scl [*8];
	endsequence
	sequence start_seen;
		ce_n && scl && $past(scl) && $fell(sda);
	endsequence
	a_reset_idle: assert property ($rose(RST_B) |-> scl && ce_n && sda)
		else $error("link not idle after reset");
	// Past ce_n guards the hand-over from a three-wire frame
	a_dev_edge_low: assert property (ce_n && $past(ce_n, 4) && $changed(dev_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	a_ack_stable: assert property (ce_n && $rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
		else $error("device drive dropped in clock high");
	a_frame_len: assert property ($rose(ce_n) |-> rise_cnt_reg == SPI_LAST_CLK)
		else $error("frame clock count wrong");
	a_frame_end: assert property ($rose(ce_n) |-> clk_parked)
		else $error("clock moved after frame");
	a_frame_open: assert property ($fell(ce_n) |-> scl)
		else $error("frame opened with clock low");
	a_no_early_drive: assert property (!ce_n && rise_cnt_reg < SPI_REG_LAST |-> !dev_sda_oe)
		else $error("device drove before register byte");
	a_start_clk: assert property (start_seen |-> ##[1:200] !scl)
		else $error("no clock after start");
	a_stop_idle: assert property (ce_n && scl && $past(scl) && $rose(sda) |-> clk_parked)
		else $error("bus not idle after stop");
endmodule

/* File: testbench/csp_tb.sv */
`timescale 1ns/1ps
module testbench
	import csp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rdata;
	logic [7:0] adc [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
	logic [7:0] dev_reg [7];
	logic [7:0] spare_pre;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic [7:0] mon_sh = 8'h00;
	int mon_cnt = 8;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	csp_if lnk();
	csp_if spare();
	csp_host csp_host_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(lnk.host), .ADDR(addr),
		.WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata));
	csp_device csp_device_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(lnk.dev),
		.BATT_CODE(adc[0]), .THERM_CODE(adc[1]), .AUX1_CODE(adc[2]), .AUX2_CODE(adc[3]),
		.PRECHARGE_TIMER(dev_reg[0]), .CONST_CURRENT_TIMER(dev_reg[1]),
		.TOTAL_CHARGE_TIMER(dev_reg[2]), .TEMP_LIMIT_HIGH_UPPER(dev_reg[3]),
		.TEMP_LIMIT_HIGH_LOWER(dev_reg[4]), .TEMP_LIMIT_LOW(dev_reg[5]),
		.SENSE_AND_TERMINATION(dev_reg[6]));
	// Second device faces a bench driver that breaks frame rules
	csp_device csp_device_inst_b (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(spare.dev),
		.BATT_CODE(adc[0]), .THERM_CODE(adc[1]), .AUX1_CODE(adc[2]), .AUX2_CODE(adc[3]),
		.PRECHARGE_TIMER(spare_pre), .CONST_CURRENT_TIMER(), .TOTAL_CHARGE_TIMER(),
		.TEMP_LIMIT_HIGH_UPPER(), .TEMP_LIMIT_HIGH_LOWER(), .TEMP_LIMIT_LOW(),
		.SENSE_AND_TERMINATION());
	csp_link_sva csp_link_sva_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .scl(lnk.scl),
		.ce_n(lnk.ce_n), .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe),
		.dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda));
	always #5 ref_clk = ~ref_clk;
	// ----------------------------------------
	// Wire monitor and timeout
	// ----------------------------------------
	// Keeps the first byte after the latest start
	always @(posedge ref_clk)
	begin
		scl_q <= lnk.scl;
		sda_q <= lnk.sda;
		if (lnk.ce_n && lnk.scl && scl_q && sda_q && !lnk.sda)
			mon_cnt <= 0;
		else if (lnk.scl && !scl_q && mon_cnt < 8)
		begin
			mon_sh <= {mon_sh[6:0], lnk.sda};
			mon_cnt <= mon_cnt + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 100000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask
	task automatic xfer(input logic [7:0] r, input logic [7:0] d, input logic [2:0] c,
		output logic [7:0] q);
		logic [7:0] s;
		reg_wr(H_REG, r);
		reg_wr(H_WDATA, d);
		reg_wr(H_CTRL, {5'h00, c});
		s = 8'h01;
		for (int i = 0; i < 20000 && s[0] !== 1'b0; i++)
			reg_rd(H_STATUS, s);
		check({6'h00, s[1] & ~c[2], s[0]}, 8'h00);
		reg_rd(H_RDATA, q);
	endtask
	task automatic spi_frame(input int n, input logic [7:0] a, input logic [7:0] d);
		logic [25:0] v;
		v = {2'b00, a, OFS_PRECHARGE, d};
		@(posedge ref_clk);
		spare.ce_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			repeat (4) @(posedge ref_clk);
			spare.scl <= 1'b0;
			spare.host_sda_oe <= (i < 26) ? ~v[25 - i] : 1'b0;
			repeat (4) @(posedge ref_clk);
			spare.scl <= 1'b1;
		end
		repeat (4) @(posedge ref_clk);
		spare.ce_n <= 1'b1;
		spare.host_sda_oe <= 1'b0;
		repeat (40) @(posedge ref_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			check(dev_reg[i], (i == 2) ? RST_TOTAL : RST_ZERO);
		$display("test reset values done");
	endtask
	task automatic t_spi_masks();
		logic [7:0] m [7] = '{MASK_PRECHARGE, MASK_CC, MASK_TOTAL, 8'hff, 8'hff, 8'hff, MASK_SENSE};
		logic [7:0] q;
		for (int i = 0; i < 7; i++)
		begin
			xfer(OFS_PRECHARGE + 8'(i), 8'hff, 3'h5, q);
			check(dev_reg[i], m[i]);
		end
		xfer(OFS_SENSE, 8'h00, 3'h7, q);
		check(q, MASK_SENSE);
		$display("test three-wire masks done");
	endtask
	task automatic t_i2c();
		logic [7:0] q;
		xfer(OFS_TEMP_HL, 8'h5a, 3'h1, q);
		check(dev_reg[4], 8'h5a);
		check(mon_sh, ADDR_WR);
		xfer(OFS_TEMP_HL, 8'h00, 3'h3, q);
		check(q, 8'h5a);
		check(mon_sh, ADDR_RD);
		check({6'h00, lnk.scl, lnk.sda}, 8'h03);
		$display("test two-wire write and read done");
	endtask
	task automatic t_results();
		logic [7:0] q;
		xfer(OFS_BATT, 8'hff, 3'h5, q);
		for (int i = 0; i < 4; i++)
		begin
			xfer(OFS_BATT + 8'(i), 8'h00, (i == 0) ? 3'h3 : 3'h7, q);
			check(q, adc[i]);
		end
		$display("test read-only results done");
	endtask
	// Short frame must leave the register alone
	task automatic t_abort();
		spi_frame(20, ADDR_WR, 8'h84);
		check(spare_pre, RST_ZERO);
		spi_frame(27, 8'h48, 8'h84);
		check(spare_pre, RST_ZERO);
		spi_frame(27, ADDR_WR, 8'h84);
		check(spare_pre, 8'h84);
		$display("test aborted frame done");
	endtask
	// Foreign address must get no acknowledge
	task automatic t_bad_addr();
		logic [7:0] v;
		v = 8'h48;
		@(posedge ref_clk);
		spare.host_sda_oe <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 9; i++)
		begin
			spare.scl <= 1'b0;
			repeat (2) @(posedge ref_clk);
			spare.host_sda_oe <= (i < 8) ? ~v[7 - i] : 1'b0;
			repeat (2) @(posedge ref_clk);
			spare.scl <= 1'b1;
			repeat (4) @(posedge ref_clk);
		end
		check({7'h00, spare.dev_sda_oe}, 8'h00);
		spare.scl <= 1'b0;
		repeat (2) @(posedge ref_clk);
		spare.host_sda_oe <= 1'b1;
		repeat (2) @(posedge ref_clk);
		spare.scl <= 1'b1;
		repeat (4) @(posedge ref_clk);
		spare.host_sda_oe <= 1'b0;
		repeat (8) @(posedge ref_clk);
		$display("test foreign address done");
	endtask
	initial
	begin
		spare.scl = 1'b1;
		spare.ce_n = 1'b1;
		spare.host_sda_o = 1'b0;
		spare.host_sda_oe = 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_spi_masks();
		t_i2c();
		t_results();
		t_abort();
		t_bad_addr();
		print_verdict();
	end
endmodule
